/* disc_dsp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module disc_dsp_model (
    input  wire       aclk,                  // clock
    input  wire       aresetn,               // reset, low active
    input  wire [1:0] fmt,                   // wiring scheme in use
    input  wire       subcode_bit_clock_out, // bit clock from device
    input  wire       bit_clock_oe,          // bit clock driven
    input  wire [3:0] gp_out,                // device pin values
    input  wire [3:0] gp_oe,                 // device pin enables
    input  wire [3:0] pin_level,             // level of undriven pins
    output wire       subcode_data_line,     // subcode data
    output wire       frame_sync_line,       // byte clock
    output wire       block_sync_line,       // sync clock
    output wire [3:0] gp_in                  // resolved pin levels
);
    reg [7:0] sh_ff;
    reg [2:0] bit_cnt_ff;
    reg       clk_d_ff;
    // data moves only on bit clock rises, so it stands still while the bit clock is not driven
    always @(posedge aclk) begin
        clk_d_ff <= subcode_bit_clock_out;
        if (!aresetn) begin
            sh_ff <= 8'ha5;
            bit_cnt_ff <= 3'h0;
        end else if (bit_clock_oe && subcode_bit_clock_out && !clk_d_ff) begin
            sh_ff <= {sh_ff[6:0], ~(sh_ff[7] ^ sh_ff[4])};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
    end
    assign subcode_data_line = sh_ff[7];
    assign frame_sync_line = (fmt != 2'b00) && (bit_cnt_ff == 3'h0);
    assign block_sync_line = (fmt == 2'b01) && (bit_cnt_ff == 3'h0) && sh_ff[0];
    assign gp_in = (gp_oe & gp_out) | (~gp_oe & pin_level);
endmodule
`default_nettype wire

/* subcode_gpio_audio_regs.vh */
`ifndef SUBCODE_GPIO_AUDIO_REGS_VH
`define SUBCODE_GPIO_AUDIO_REGS_VH

// register indices; byte address is four times the index
`define SUBSEL_IDX      10'h042
`define VERSION_IDX     10'h043
`define PORTCTL_IDX     10'h044
`define RSVD_A_IDX      10'h045
`define RSVD_B_IDX      10'h046
`define RSVD_C_IDX      10'h047
`define BLKCNT_IDX      10'h048
`define RSVD_D_IDX      10'h049
`define BLKADDR_IDX     10'h04a
`define RSVD_E_IDX      10'h04b
`define PLAYCTL_IDX     10'h060

// subcode format field
`define SUBFMT_MSB      7
`define SUBFMT_LSB      6
`define SUBFMT_COMBINED 2'b00
`define SUBFMT_FOUR     2'b01
`define SUBFMT_THREE    2'b10
`define SUBFMT_INVALID  2'b11

// port control fields
`define PORT_DIR_MSB    7
`define PORT_DIR_LSB    4
`define PORT_VAL_MSB    3
`define PORT_VAL_LSB    0

// playback control fields
`define PLAY_START_BIT  0
`define PLAY_BYPASS_BIT 1

// reset values
`define SUBSEL_RST      2'b00
`define PORT_DIR_RST    4'h0
`define PORT_VAL_RST    4'h0
`define BLKCNT_RST      8'h00
`define BLKADDR_RST     8'h00

// axi responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

/* subcode_select_gpio_audio_regs.v */
// Overview of operation
// R1: format 00 takes subcode on one combined line, sync lines grounded, internal clock.
// R2: format 01 is four-wire: byte clock, sync input, device drives bit clock.
// R3: format 10 is three-wire: frame line is byte/sync clock; 11 is invalid.
// R4: subcode format field sits in bits 7:6; bits 5:0 reserved.
// R5: version register is a fixed eight-bit code, writes ignored.
// R6: port control bits 7..4 set pin 3..0 direction, one means output.
// R7: an output pin follows its written value bit, high for one.
// R8: an input pin's value bit reads the sampled pin level.
// R9: eight-bit valid audio block count, readable and writable.
// R10: readable and writable address of the block sent to the DAC.
// R11: offsets 45h, 46h, 47h, 49h and 4Bh are reserved.
// R12: start bit with bypass clear starts playback from the block address register.
// R13: after reset all pins are inputs and reserved registers read zero.
`timescale 1ns/1ps
`default_nettype none
`include "subcode_gpio_audio_regs.vh"

module subcode_select_gpio_audio_regs #(
    parameter [7:0] VERSION_CODE = 8'h5a,   // arbitrary value
    parameter       BITCLK_DIV   = 4        // half period of bit clock in aclk cycles
) (
    input  wire        aclk,                // clock
    input  wire        aresetn,             // synchronous reset, low active
    input  wire [11:0] s_axi_awaddr,        // write address
    input  wire        s_axi_awvalid,       // write address valid
    output wire        s_axi_awready,       // write address ready
    input  wire [31:0] s_axi_wdata,         // write data
    input  wire [3:0]  s_axi_wstrb,         // write strobes
    input  wire        s_axi_wvalid,        // write data valid
    output wire        s_axi_wready,        // write data ready
    output wire [1:0]  s_axi_bresp,         // write response
    output wire        s_axi_bvalid,        // write response valid
    input  wire        s_axi_bready,        // write response ready
    input  wire [11:0] s_axi_araddr,        // read address
    input  wire        s_axi_arvalid,       // read address valid
    output wire        s_axi_arready,       // read address ready
    output wire [31:0] s_axi_rdata,         // read data
    output wire [1:0]  s_axi_rresp,         // read response
    output wire        s_axi_rvalid,        // read data valid
    input  wire        s_axi_rready,        // read data ready
    input  wire        subcode_data_line,   // subcode serial input
    input  wire        frame_sync_line,     // byte clock or byte/sync clock
    input  wire        block_sync_line,     // sync clock in four-wire mode
    output wire        subcode_bit_clock_out, // bit clock to the signal processor
    output wire        bit_clock_oe,        // bit clock driven
    output wire        internal_clock_sel,  // combined mode uses internal clock
    output reg         sub_data_ff,         // sampled subcode data
    output reg         sub_byte_clk_ff,     // sampled byte clock
    output reg         sub_sync_ff,         // sampled sync
    output wire        sub_format_invalid,  // field holds the invalid code
    input  wire [3:0]  gp_in,               // general pin levels
    output wire [3:0]  gp_out,              // general pin drive value
    output wire [3:0]  gp_oe,               // general pin drive enable
    input  wire        block_done,          // playback finished the current block
    output wire        play_active,         // playback running
    output reg         play_start_ff,       // one-cycle pulse on playback start
    output wire [7:0]  play_block_addr      // block being played
);

    // divider is eight bits wide: BITCLK_DIV up to 256
    localparam [31:0] DIV_FULL = BITCLK_DIV - 1;
    localparam [7:0]  DIV_LAST = DIV_FULL[7:0];

    // software fields
    reg  [1:0]  subfmt_ff;
    reg  [3:0]  gp_dir_ff;
    reg  [3:0]  gp_val_ff;
    reg  [7:0]  blkcnt_ff;
    reg  [7:0]  blkaddr_ff;

    // playback control
    reg         start_ff;
    reg         bypass_ff;
    reg         play_prev_ff;

    // bit clock divider
    reg  [7:0]  div_cnt_ff;
    reg         bitclk_ff;

    // write channel
    reg         aw_held_ff;
    reg  [11:0] awaddr_ff;
    reg         w_held_ff;
    reg  [31:0] wdata_ff;
    reg  [3:0]  wstrb_ff;
    reg         bvalid_ff;
    reg  [1:0]  bresp_ff;

    // read channel
    reg         rvalid_ff;
    reg  [31:0] rdata_ff;
    reg  [1:0]  rresp_ff;

    reg  [7:0]  rd_byte;
    reg         rd_hit;
    reg         wr_hit;

    // only byte lane 0 carries data
    wire        do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire [9:0]  wr_idx   = awaddr_ff[11:2];
    wire        wr_lane0 = do_write & wstrb_ff[0];
    wire [7:0]  wbyte    = wdata_ff[7:0];
    wire        four_wire  = (subfmt_ff == `SUBFMT_FOUR);
    wire        three_wire = (subfmt_ff == `SUBFMT_THREE);
    // outputs read back, inputs read the pin
    wire [3:0]  gp_level = (gp_dir_ff & gp_val_ff) | (~gp_dir_ff & gp_in);  // R8

    // a held channel or a pending response
    // blocks new writes: one write in flight,
    // one read likewise; bvalid follows the
    // later of the two halves by one cycle
    assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    assign gp_oe  = gp_dir_ff;  // R6
    assign gp_out = gp_val_ff;  // R7

    // 00: one combined line, internal clock
    // 01: four wires, separate sync line
    // 10: three wires, shared frame line
    // 11: invalid, clock low, syncs idle
    // bit clock driven in 01 and 10 only
    assign sub_format_invalid    = (subfmt_ff == `SUBFMT_INVALID);  // R3
    assign internal_clock_sel    = (subfmt_ff == `SUBFMT_COMBINED);  // R1
    assign bit_clock_oe          = four_wire | three_wire;  // R2
    assign subcode_bit_clock_out = bitclk_ff;

    // bypass keeps playback off regardless
    // of the start bit
    assign play_active     = start_ff & ~bypass_ff;  // R12
    assign play_block_addr = blkaddr_ff;

    // write decode; reserved and fixed registers accept and drop the data
    always @* begin
        // known slots answer okay, others error
        case (wr_idx)
            `SUBSEL_IDX,
            `VERSION_IDX,
            `PORTCTL_IDX,
            `BLKCNT_IDX,
            `BLKADDR_IDX,
            `PLAYCTL_IDX,
            `RSVD_A_IDX,
            `RSVD_B_IDX,
            `RSVD_C_IDX,
            `RSVD_D_IDX,
            `RSVD_E_IDX: begin
                wr_hit = 1'b1;  // R11
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // read decode; narrow registers sit in the low byte
    always @* begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        case (s_axi_araddr[11:2])
            // bits 5:0 read zero
            `SUBSEL_IDX: begin
                rd_byte = {subfmt_ff, 6'h00};  // R4
            end
            // hard-wired
            `VERSION_IDX: begin
                rd_byte = VERSION_CODE;  // R5
            end
            // direction, then pin levels
            `PORTCTL_IDX: begin
                rd_byte = {gp_dir_ff, gp_level};  // R8
            end
            // counts down as blocks finish
            `BLKCNT_IDX: begin
                rd_byte = blkcnt_ff;  // R9
            end
            // steps up as blocks finish
            `BLKADDR_IDX: begin
                rd_byte = blkaddr_ff;  // R10
            end
            // start and bypass as written
            `PLAYCTL_IDX: begin
                rd_byte = {6'h00, bypass_ff, start_ff};
            end
            `RSVD_A_IDX,
            `RSVD_B_IDX,
            `RSVD_C_IDX,
            `RSVD_D_IDX,
            `RSVD_E_IDX: begin
                rd_byte = 8'h00;  // R11
            end
            // unmapped: zero data, error
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // bus channels
    always @(posedge aclk) begin
        if (!aresetn) begin
            // drops any half-done transfer
            aw_held_ff <= 1'b0;
            awaddr_ff  <= 12'h000;
            w_held_ff  <= 1'b0;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= {24'h000000, rd_byte};
                rresp_ff  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // register file and playback address tracking
    always @(posedge aclk) begin
        if (!aresetn) begin
            subfmt_ff     <= `SUBSEL_RST;
            gp_dir_ff     <= `PORT_DIR_RST;  // R13
            gp_val_ff     <= `PORT_VAL_RST;
            blkcnt_ff     <= `BLKCNT_RST;
            blkaddr_ff    <= `BLKADDR_RST;
            start_ff      <= 1'b0;
            bypass_ff     <= 1'b0;
            play_prev_ff  <= 1'b0;
            play_start_ff <= 1'b0;
        end else begin
            play_prev_ff  <= play_active;
            play_start_ff <= play_active & ~play_prev_ff;  // R12

            // a finished block moves on; a software write in the same cycle wins
            if (block_done && play_active) begin
                blkaddr_ff <= blkaddr_ff + 8'h01;  // R10
                // stops at zero, never wraps
                if (blkcnt_ff != 8'h00) begin
                    blkcnt_ff <= blkcnt_ff - 8'h01;  // R9
                end
            end

            // version and reserved slots change nothing
            if (wr_lane0) begin
                case (wr_idx)
                    // only the format field is kept
                    `SUBSEL_IDX: begin
                        subfmt_ff <= wbyte[`SUBFMT_MSB:`SUBFMT_LSB];  // R4
                    end
                    // both nibbles load together
                    `PORTCTL_IDX: begin
                        gp_dir_ff <= wbyte[`PORT_DIR_MSB:`PORT_DIR_LSB];  // R6
                        gp_val_ff <= wbyte[`PORT_VAL_MSB:`PORT_VAL_LSB];  // R7
                    end
                    `BLKCNT_IDX: begin
                        blkcnt_ff <= wbyte;  // R9
                    end
                    `BLKADDR_IDX: begin
                        blkaddr_ff <= wbyte;  // R10
                    end
                    // start and bypass load together
                    `PLAYCTL_IDX: begin
                        start_ff  <= wbyte[`PLAY_START_BIT];
                        bypass_ff <= wbyte[`PLAY_BYPASS_BIT];
                    end
                    default: begin
                        start_ff <= start_ff;  // R5
                    end
                endcase
            end
        end
    end

    // bit clock runs only in the wired schemes, held low otherwise
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_ff <= 8'h00;
            bitclk_ff  <= 1'b0;
        end else if (bit_clock_oe) begin  // R2 R3
            // restarts from zero when enabled, so
            // the first high phase is a full one;
            // the clock runs free between frames
            if (div_cnt_ff == DIV_LAST) begin
                div_cnt_ff <= 8'h00;
                bitclk_ff  <= ~bitclk_ff;
            end else begin
                div_cnt_ff <= div_cnt_ff + 8'h01;
            end
        end else begin
            div_cnt_ff <= 8'h00;  // R1
            bitclk_ff  <= 1'b0;
        end
    end

    // subcode input routing per scheme; grounded lines are ignored
    // sampled one cycle late, no byte alignment
    // invalid code keeps both sync outputs low
    always @(posedge aclk) begin
        if (!aresetn) begin
            sub_data_ff     <= 1'b0;
            sub_byte_clk_ff <= 1'b0;
            sub_sync_ff     <= 1'b0;
        end else begin
            sub_data_ff     <= subcode_data_line;
            sub_byte_clk_ff <= (four_wire | three_wire) & frame_sync_line;  // R2 R3
            sub_sync_ff     <= (four_wire & block_sync_line) |
                               (three_wire & frame_sync_line);  // R2 R3
        end
    end

endmodule
`default_nettype wire

/* subcode_select_gpio_audio_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module regs_checker #(
    parameter BITCLK_DIV = 4 // bit clock half period
) (
    input wire        aclk,                  // clock
    input wire        aresetn,               // reset, low active
    input wire        s_axi_bvalid,          // write response valid
    input wire        s_axi_bready,          // write response ready
    input wire [1:0]  s_axi_bresp,           // write response
    input wire        s_axi_rvalid,          // read valid
    input wire        s_axi_rready,          // read ready
    input wire [31:0] s_axi_rdata,           // read data
    input wire [1:0]  s_axi_rresp,           // read response
    input wire        subcode_bit_clock_out, // bit clock
    input wire        bit_clock_oe,          // bit clock enable
    input wire        internal_clock_sel,    // combined mode
    input wire        sub_byte_clk_ff,       // sampled byte clock
    input wire        sub_sync_ff,           // sampled sync
    input wire        subcode_data_line,     // data line
    input wire        frame_sync_line,       // frame line
    input wire        sub_data_ff,           // sampled data
    input wire        sub_format_invalid,    // invalid code
    input wire [3:0]  gp_oe,                 // pin enables
    input wire        play_active,           // playback running
    input wire        play_start_ff,         // start pulse
    input wire        block_done,            // block finished
    input wire [7:0]  play_block_addr        // block address
);
    reg [7:0] hi_cnt_ff;
    // length of the current high phase of the bit clock
    always @(posedge aclk) begin
        if (!aresetn || !subcode_bit_clock_out)
            hi_cnt_ff <= 8'h00;
        else
            hi_cnt_ff <= hi_cnt_ff + 8'h01;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rdata_narrow:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above byte not zero");
    a_read_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_bresp_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_error_zero:
        assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    a_mode_exclusive:
        assert property (bit_clock_oe |-> !internal_clock_sel && !sub_format_invalid)
        else $error("bit clock driven outside clocked schemes");
    a_combined_quiet:
        assert property (internal_clock_sel |=> !sub_byte_clk_ff && !sub_sync_ff)
        else $error("sync outputs active in combined mode");
    a_clock_idle:
        assert property (!bit_clock_oe [*2] |-> !subcode_bit_clock_out)
        else $error("bit clock toggles while not driven");
    a_clock_half:
        assert property ($fell(subcode_bit_clock_out) && bit_clock_oe |-> hi_cnt_ff == BITCLK_DIV)
        else $error("bit clock high phase wrong");
    a_pins_reset:
        assert property ($rose(aresetn) |-> gp_oe == 4'h0 && !play_active)
        else $error("pins or playback active after reset");
    a_start_pulse:
        assert property ($rose(play_active) |=> play_start_ff)
        else $error("no start pulse");
    a_addr_step:
        assert property (play_active && block_done |=> play_block_addr == $past(play_block_addr) + 8'h01)
        else $error("block address did not advance");
    a_data_delay:
        assert property (1'b1 |=> sub_data_ff == $past(subcode_data_line))
        else $error("subcode data not sampled one cycle late");
    a_byte_delay:
        assert property (bit_clock_oe |=> sub_byte_clk_ff == $past(frame_sync_line))
        else $error("byte clock not sampled one cycle late");
    c_play: cover property ($rose(play_active));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    c_bitclk: cover property ($fell(subcode_bit_clock_out) && bit_clock_oe);
endmodule
bind subcode_select_gpio_audio_regs regs_checker #(.BITCLK_DIV(BITCLK_DIV)) chk_i (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .subcode_bit_clock_out, .bit_clock_oe, .internal_clock_sel,
    .sub_byte_clk_ff, .sub_sync_ff, .sub_format_invalid, .gp_oe, .play_active, .play_start_ff,
    .block_done, .play_block_addr, .subcode_data_line, .frame_sync_line, .sub_data_ff);
`default_nettype wire

/* subcode_select_gpio_audio_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module subcode_select_gpio_audio_regs_tb;
    localparam [7:0] VER = 8'h3c; // arbitrary version code
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, block_done;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, r;
    logic [3:0]  s_axi_wstrb, pin_level;
    logic [1:0]  fmt;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         subcode_data_line, frame_sync_line, block_sync_line, subcode_bit_clock_out;
    wire         bit_clock_oe, internal_clock_sel, sub_data_ff, sub_byte_clk_ff, sub_sync_ff;
    wire         sub_format_invalid, play_active, play_start_ff;
    wire  [3:0]  gp_in, gp_out, gp_oe;
    wire  [7:0]  play_block_addr;
    logic [34:0] exp_q[$];
    logic [34:0] e;
    logic [11:0] rsv[5] = '{12'h114, 12'h118, 12'h11c, 12'h124, 12'h12c};
    logic [1:0]  modes[4] = '{2'b01, 2'b00, 2'b10, 2'b11};
    int          err_count, comparisons, n;
    integer      seed = 32'hda643ce2;
    subcode_select_gpio_audio_regs #(.VERSION_CODE(VER), .BITCLK_DIV(4)) subcode_select_gpio_audio_regs_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .subcode_data_line, .frame_sync_line, .block_sync_line, .subcode_bit_clock_out,
        .bit_clock_oe, .internal_clock_sel, .sub_data_ff, .sub_byte_clk_ff, .sub_sync_ff,
        .sub_format_invalid, .gp_in, .gp_out, .gp_oe, .block_done, .play_active, .play_start_ff,
        .play_block_addr);
    disc_dsp_model disc_dsp_model_i (.aclk, .aresetn, .fmt, .subcode_bit_clock_out,
        .bit_clock_oe, .gp_out, .gp_oe, .pin_level, .subcode_data_line, .frame_sync_line,
        .block_sync_line, .gp_in);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic lim;
        if (n >= 40) begin
            err_count++;
            print_verdict;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rsp);
        bit aw_ok, w_ok;
        @(posedge aclk);
        exp_q.push_back({1'b0, rsp, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($random(seed)), d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_ok = 0;
        w_ok = 0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) aw_ok = 1;
            if (s_axi_wready) w_ok = 1;
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end while (!(aw_ok && w_ok) && n < 40);
        lim;
        for (n = 0; n < 40 && !s_axi_bvalid; n++) @(posedge aclk);
        lim;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rsp);
        @(posedge aclk);
        exp_q.push_back({1'b1, rsp, 24'h0, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_arready && n < 40);
        lim;
        s_axi_arvalid <= 1'b0;
        for (n = 0; n < 40 && !s_axi_rvalid; n++) @(posedge aclk);
        lim;
        s_axi_rready <= 1'b0;
    endtask
    // responses are judged here, in the order the requests were made
    always @(posedge aclk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            e = exp_q.pop_front();
            if (e[34])
                chk({s_axi_rresp, s_axi_rdata}, e[33:0]);
            else
                chk({s_axi_bresp, 32'h0}, e[33:0]);
        end
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hf;
        pin_level = 4'h0;
        fmt = 2'b00;
        block_done = 1'b0;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h10c, VER, 2'b00);
        wr(12'h10c, 8'hff, 2'b00);
        rd(12'h10c, VER, 2'b00);
        rd(12'h108, 8'h00, 2'b00);
        foreach (rsv[i]) begin
            wr(rsv[i], 8'hff, 2'b00);
            rd(rsv[i], 8'h00, 2'b00);
        end
        wr(12'h3fc, 8'h55, 2'b10);
        rd(12'h3fc, 8'h00, 2'b10);
        foreach (modes[i]) begin
            fmt <= modes[i];
            wr(12'h108, {modes[i], 6'h3f}, 2'b00);
            rd(12'h108, {modes[i], 6'h00}, 2'b00);
            repeat (40) @(posedge aclk);
            chk({internal_clock_sel, bit_clock_oe, sub_format_invalid},
                {modes[i] == 2'b00, modes[i] == 2'b01 || modes[i] == 2'b10, modes[i] == 2'b11});
        end
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            pin_level <= r[11:8];
            wr(12'h110, r[7:0], 2'b00);
            rd(12'h110, {r[7:4], (r[3:0] & r[7:4]) | (r[11:8] & ~r[7:4])}, 2'b00);
            chk({gp_oe, gp_out}, r[7:0]);
        end
        r = $random(seed);
        wr(12'h128, r[15:8], 2'b00);
        wr(12'h180, 8'h03, 2'b00);
        chk(play_active, 1'b0);
        wr(12'h180, 8'h01, 2'b00);
        @(posedge aclk);
        chk({play_active, play_block_addr}, {1'b1, r[15:8]});
        for (int k = 0; k < 2; k++) begin
            wr(12'h120, k ? 8'h00 : r[7:0], 2'b00);
            block_done <= 1'b1;
            @(posedge aclk);
            block_done <= 1'b0;
            rd(12'h120, (k || r[7:0] == 8'h00) ? 8'h00 : r[7:0] - 8'h01, 2'b00);
            rd(12'h128, r[15:8] + 8'(k + 1), 2'b00);
        end
        print_verdict;
    end
endmodule
`default_nettype wire
